// ==== core/dtcu_unit.sv ====
// Training command unit of a low-power DRAM die: command decode on ck,
// mode registers, calibration bursts, preamble training and the interval
// oscillator. Assumes cs/ca are launched on ck; data beats are serialised
// outside as rise/fall pairs; the oscillator counter runs on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dtcu_unit #(
  parameter int RD_LAT = 14
) (
  // Clocks, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic ck,
  // Command bus
  input wire logic cs,
  input wire logic [5:0] ca,
  // Read data beats
  output logic [15:0] dq_rise,
  output logic [15:0] dq_fall,
  output logic dq_oe,
  output logic [1:0] dmi_rise,
  output logic [1:0] dmi_fall,
  // Strobe pair
  output logic dqs_t_rise,
  output logic dqs_t_fall,
  output logic dqs_c_rise,
  output logic dqs_c_fall,
  output logic dqs_oe,
  // Training side effects
  output logic fifo_wr_go,
  output logic fifo_rd_go,
  output logic [4:0] train_beats,
  output logic zq_start,
  output logic zq_latch
);
  // Refuse latencies that the pipeline cannot be built for.
  if (RD_LAT < 3 || RD_LAT > 64) begin : g_bad_rd_lat
    $error("RD_LAT out of range");
  end

  dtcu_pkg::dtcu_dec_e st;
  dtcu_pkg::dtcu_wait_e await_kind;
  logic [5:0] ca_first;
  logic [5:0] mrw_ma;
  logic mrw_op7;
  logic [5:0] mrr_ma;
  logic [7:0] pat_first;
  logic [7:0] pat_second;
  logic [7:0] inv_low;
  logic [7:0] inv_high;
  logic [7:0] train_ctrl;
  logic [7:0] osc_auto_stop_setting;
  logic [7:0] osc_count_low;
  logic [7:0] osc_count_high;
  logic pre_active;
  logic [RD_LAT-2:0] lat_pipe;
  logic [RD_LAT-2:0] mrr_pipe;
  logic bursting;
  logic burst_mrr;
  logic [2:0] beat_clk;
  logic [7:0] mrr_val;
  logic osc_start_tgl;
  logic osc_stop_tgl;
  logic osc_run_link;
  logic [12:0] auto_cnt;
  logic [2:0] done_sync;
  logic done_seen;
  logic osc_run;
  logic [15:0] osc_cnt;
  logic [15:0] osc_result;
  logic osc_done_tgl;
  logic [2:0] start_sync;
  logic [2:0] stop_sync;
  logic start_seen;
  logic stop_seen;

  // A two-edge command completes when the second edge samples cs low.
  logic cmd_done;
  logic [4:0] kind;
  logic [6:0] op;
  logic mpc_fire;
  logic cas_fire;
  logic launch;
  logic osc_stop_now;
  assign cmd_done = (st == dtcu_pkg::DS_EDGE2) && !cs;
  assign kind = ca_first[4:0];
  assign op = {ca_first[5], ca};
  assign mpc_fire = cmd_done && kind == dtcu_pkg::CMD_MPC && op[6];
  assign cas_fire = cmd_done && kind == dtcu_pkg::CMD_CAS2;
  assign launch = cas_fire && (await_kind == dtcu_pkg::WAIT_RD_CAL
    || await_kind == dtcu_pkg::WAIT_MRR);
  assign osc_stop_now = osc_run_link && ((mpc_fire && op == dtcu_pkg::OP_OSC_STOP)
    || auto_cnt == 13'h0001);

  function automatic logic [7:0] read_reg(input logic [5:0] ma);
    case (ma)
      dtcu_pkg::MA_TRAIN_CTRL: read_reg = train_ctrl;
      dtcu_pkg::MA_INV_LOW: read_reg = inv_low;
      dtcu_pkg::MA_INV_HIGH: read_reg = inv_high;
      dtcu_pkg::MA_OSC_LOW: read_reg = osc_count_low;
      dtcu_pkg::MA_OSC_HIGH: read_reg = osc_count_high;
      dtcu_pkg::MA_AUTO_STOP: read_reg = osc_auto_stop_setting;
      dtcu_pkg::MA_PAT_FIRST: read_reg = pat_first;
      dtcu_pkg::MA_PAT_SECOND: read_reg = pat_second;
      default: read_reg = dtcu_pkg::RST_REG;
    endcase
  endfunction

  // Pattern bit of beat idx: first byte for beats 0-7, second for 8-15.
  function automatic logic cal_bit(input logic [3:0] idx);
    cal_bit = idx[3] ? pat_second[idx[2:0]] : pat_first[idx[2:0]];
  endfunction

  // Two-edge command framing.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      st <= dtcu_pkg::DS_IDLE;
      ca_first <= 6'h00;
    end else begin
      case (st)
        dtcu_pkg::DS_IDLE: begin
          if (cs) begin
            ca_first <= ca;
            st <= dtcu_pkg::DS_EDGE2;
          end
        end
        dtcu_pkg::DS_EDGE2: begin
          if (cs) begin
            ca_first <= ca;
          end else begin
            st <= dtcu_pkg::DS_IDLE;
          end
        end
        default: st <= dtcu_pkg::DS_IDLE;
      endcase
    end
  end

  // Pairing of read/write training and register reads with a CAS-2 that is the very next command.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      await_kind <= dtcu_pkg::WAIT_NONE;
      mrr_ma <= 6'h00;
    end else if (cmd_done) begin
      await_kind <= dtcu_pkg::WAIT_NONE;
      if (mpc_fire) begin
        case (op)
          dtcu_pkg::OP_RD_CAL: await_kind <= dtcu_pkg::WAIT_RD_CAL;
          dtcu_pkg::OP_RD_FIFO: await_kind <= dtcu_pkg::WAIT_RD_FIFO;
          dtcu_pkg::OP_WR_FIFO: await_kind <= dtcu_pkg::WAIT_WR_FIFO;
          default: await_kind <= dtcu_pkg::WAIT_NONE;
        endcase
      end else if (kind == dtcu_pkg::CMD_MRR1) begin
        mrr_ma <= ca;
        await_kind <= dtcu_pkg::WAIT_MRR;
      end
    end
  end

  // FIFO go pulses and impedance calibration pulses.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      fifo_wr_go <= 1'b0;
      fifo_rd_go <= 1'b0;
      train_beats <= 5'h00;
      zq_start <= 1'b0;
      zq_latch <= 1'b0;
    end else begin
      fifo_wr_go <= cas_fire && await_kind == dtcu_pkg::WAIT_WR_FIFO;
      fifo_rd_go <= cas_fire && await_kind == dtcu_pkg::WAIT_RD_FIFO;
      if (cas_fire && (await_kind == dtcu_pkg::WAIT_WR_FIFO
          || await_kind == dtcu_pkg::WAIT_RD_FIFO)) begin
        train_beats <= dtcu_pkg::FIFO_BEATS;
      end
      zq_start <= mpc_fire && op == dtcu_pkg::OP_ZQ_START;
      zq_latch <= mpc_fire && op == dtcu_pkg::OP_ZQ_LATCH;
    end
  end

  // Mode register writes; the oscillator result registers are read-only.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      mrw_ma <= 6'h00;
      mrw_op7 <= 1'b0;
      pat_first <= dtcu_pkg::RST_PAT_FIRST;
      pat_second <= dtcu_pkg::RST_PAT_SECOND;
      inv_low <= dtcu_pkg::RST_REG;
      inv_high <= dtcu_pkg::RST_REG;
      train_ctrl <= dtcu_pkg::RST_REG;
      osc_auto_stop_setting <= dtcu_pkg::RST_REG;
    end else if (cmd_done && kind == dtcu_pkg::CMD_MRW1) begin
      mrw_ma <= ca;
      mrw_op7 <= ca_first[5];
    end else if (cmd_done && kind == dtcu_pkg::CMD_MRW2) begin
      case (mrw_ma)
        dtcu_pkg::MA_PAT_FIRST: pat_first <= {mrw_op7, op};
        dtcu_pkg::MA_PAT_SECOND: pat_second <= {mrw_op7, op};
        dtcu_pkg::MA_INV_LOW: inv_low <= {mrw_op7, op};
        dtcu_pkg::MA_INV_HIGH: inv_high <= {mrw_op7, op};
        dtcu_pkg::MA_TRAIN_CTRL: train_ctrl <= {mrw_op7, op};
        dtcu_pkg::MA_AUTO_STOP: osc_auto_stop_setting <= {mrw_op7, op};
        default: mrw_op7 <= mrw_op7;
      endcase
    end
  end

  // Preamble training follows the enable bit one ck later, on entry and exit.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      pre_active <= 1'b0;
    end else begin
      pre_active <= train_ctrl[dtcu_pkg::PRE_TRAIN_BIT];
    end
  end

  // Read latency pipeline; a start meeting the last burst clock is seamless.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      lat_pipe <= '0;
      mrr_pipe <= '0;
      bursting <= 1'b0;
      burst_mrr <= 1'b0;
      beat_clk <= 3'h0;
      mrr_val <= 8'h00;
    end else begin
      lat_pipe <= {lat_pipe[RD_LAT-3:0], launch};
      mrr_pipe <= {mrr_pipe[RD_LAT-3:0], await_kind == dtcu_pkg::WAIT_MRR};
      if (lat_pipe[RD_LAT-2]) begin
        bursting <= 1'b1;
        burst_mrr <= mrr_pipe[RD_LAT-2];
        beat_clk <= 3'h0;
        mrr_val <= read_reg(mrr_ma);
      end else if (bursting) begin
        beat_clk <= beat_clk + 3'h1;
        if (beat_clk == dtcu_pkg::LAST_BURST_CLK) begin
          bursting <= 1'b0;
        end
      end
    end
  end

  // Output beats and strobes.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      dq_rise <= 16'h0000;
      dq_fall <= 16'h0000;
      dq_oe <= 1'b0;
      dmi_rise <= 2'h0;
      dmi_fall <= 2'h0;
      dqs_t_rise <= 1'b0;
      dqs_t_fall <= 1'b0;
      dqs_c_rise <= 1'b0;
      dqs_c_fall <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      dq_oe <= bursting;
      dqs_oe <= bursting || pre_active;
      if (bursting && burst_mrr) begin
        dq_rise <= {8'h00, mrr_val};
        dq_fall <= {8'h00, mrr_val};
        dmi_rise <= 2'h0;
        dmi_fall <= 2'h0;
      end else if (bursting) begin
        dq_rise <= {16{cal_bit({beat_clk, 1'b0})}} ^ {inv_high, inv_low};
        dq_fall <= {16{cal_bit({beat_clk, 1'b1})}} ^ {inv_high, inv_low};
        dmi_rise <= {2{cal_bit({beat_clk, 1'b0})}};
        dmi_fall <= {2{cal_bit({beat_clk, 1'b1})}};
      end else begin
        dq_rise <= 16'h0000;
        dq_fall <= 16'h0000;
        dmi_rise <= 2'h0;
        dmi_fall <= 2'h0;
      end
      // Bursts toggle the pair; training holds it static with no preamble.
      dqs_t_rise <= bursting;
      dqs_t_fall <= 1'b0;
      dqs_c_rise <= !bursting && pre_active;
      dqs_c_fall <= bursting || pre_active;
    end
  end

  // Oscillator control on ck: start/stop toggles and the auto-stop timer.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      osc_start_tgl <= 1'b0;
      osc_stop_tgl <= 1'b0;
      osc_run_link <= 1'b0;
      auto_cnt <= 13'h0000;
    end else if (osc_stop_now) begin
      osc_stop_tgl <= !osc_stop_tgl;
      osc_run_link <= 1'b0;
      auto_cnt <= 13'h0000;
    end else if (mpc_fire && op == dtcu_pkg::OP_OSC_START) begin
      osc_start_tgl <= !osc_start_tgl;
      osc_run_link <= 1'b1;
      auto_cnt <= 13'({osc_auto_stop_setting, 4'h0});
    end else if (auto_cnt != 13'h0000) begin
      auto_cnt <= auto_cnt - 13'h0001;
    end
  end

  // Result crossing back to ck; the word is written with the toggle and is stable before the synchronised toggle is seen.
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      done_sync <= 3'h0;
      done_seen <= 1'b0;
      osc_count_low <= dtcu_pkg::RST_REG;
      osc_count_high <= dtcu_pkg::RST_REG;
    end else begin
      done_sync <= {done_sync[1:0], osc_done_tgl};
      if (done_sync[2] == done_sync[1] && done_sync[2] != done_seen) begin
        done_seen <= done_sync[2];
        osc_count_low <= osc_result[7:0];
        osc_count_high <= osc_result[15:8];
      end
    end
  end

  // Counter side on sys_clk; stop wins over a same-cycle increment.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_sync <= 3'h0;
      stop_sync <= 3'h0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      osc_run <= 1'b0;
      osc_cnt <= 16'h0000;
      osc_result <= 16'h0000;
      osc_done_tgl <= 1'b0;
    end else if (ce) begin
      start_sync <= {start_sync[1:0], osc_start_tgl};
      stop_sync <= {stop_sync[1:0], osc_stop_tgl};
      if (stop_sync[2] == stop_sync[1] && stop_sync[2] != stop_seen) begin
        stop_seen <= stop_sync[2];
        osc_run <= 1'b0;
        osc_result <= osc_cnt;
        osc_done_tgl <= !osc_done_tgl;
      end else if (start_sync[2] == start_sync[1] && start_sync[2] != start_seen) begin
        start_seen <= start_sync[2];
        osc_run <= 1'b1;
        osc_cnt <= 16'h0000;
      end else if (osc_run && osc_cnt != dtcu_pkg::OSC_MAX) begin
        osc_cnt <= osc_cnt + 16'h0001;
      end
    end
  end
endmodule // dtcu_unit
`default_nettype wire

// ==== core/dtcu_pkg.sv ====
// Constants shared by the training command unit: command codes, opcodes,
// mode register addresses, reset values and timing counts.
// Assumes the CA bit 0 is the least significant bit of every CA word.
//
// Notes on behaviour
// - On oscillator stop, low count byte goes to one register, high byte to another.
// - Both result registers are rewritten when a stop-oscillator command ends a run, unless ce holds the counter side.
// - The oscillator counter saturates at its maximum and never wraps.
// - Training enable set: strobe true low, complement high, held until read training.
// - During preamble training no normal read preamble is driven.
// - A read training command toggles the strobes like a normal burst after latency.
// - Each calibration pair returns 16 beats: first pattern byte then second, all pins.
// - Pins whose invert mask bit is one get the pattern inverted.
// - Pattern also drives the mask/inversion pins, with no bus inversion applied.
// - Calibration commands may repeat every column interval with seamless bursts.
// - Training enable cleared: leave preamble training within the entry/exit delay.
// - Multi-purpose command spans two edges; operand bit 6 on the first, 0 to 5 later.
// - Operand bit 6 low is a no-operation; high decodes a training command.
// - Training latency counts from the second edge of the following CAS-2.
// - Decode read FIFO, read calibration and write FIFO; RFU and others reserved.
// - Decode oscillator start and stop, impedance calibration start and latch.
// - FIFO training commands always use 16 beats, ignoring burst length field.
// - Oscillator stops by command or by auto-stop count; both latch the result.
package dtcu_pkg;
  // First-edge command codes on CA[4:0].
  localparam logic [4:0] CMD_MPC = 5'h00;
  localparam logic [4:0] CMD_MRW1 = 5'h06;
  localparam logic [4:0] CMD_MRW2 = 5'h16;
  localparam logic [4:0] CMD_MRR1 = 5'h0e;
  localparam logic [4:0] CMD_CAS2 = 5'h12;
  // Training opcodes, operand bits 6 to 0.
  localparam logic [6:0] OP_RD_FIFO = 7'h41;
  localparam logic [6:0] OP_RD_CAL = 7'h43;
  localparam logic [6:0] OP_WR_FIFO = 7'h47;
  localparam logic [6:0] OP_OSC_START = 7'h4b;
  localparam logic [6:0] OP_OSC_STOP = 7'h4d;
  localparam logic [6:0] OP_ZQ_START = 7'h4f;
  localparam logic [6:0] OP_ZQ_LATCH = 7'h51;
  // Mode register addresses and the preamble training enable bit.
  localparam logic [5:0] MA_TRAIN_CTRL = 6'h0d;
  localparam logic [5:0] MA_INV_LOW = 6'h0f;
  localparam logic [5:0] MA_OSC_LOW = 6'h12;
  localparam logic [5:0] MA_OSC_HIGH = 6'h13;
  localparam logic [5:0] MA_INV_HIGH = 6'h14;
  localparam logic [5:0] MA_AUTO_STOP = 6'h17;
  localparam logic [5:0] MA_PAT_FIRST = 6'h20;
  localparam logic [5:0] MA_PAT_SECOND = 6'h28;
  localparam int PRE_TRAIN_BIT = 1;
  // Reset values and the oscillator counter maximum.
  localparam logic [7:0] RST_PAT_FIRST = 8'h00;
  localparam logic [7:0] RST_PAT_SECOND = 8'h00;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] OSC_MAX = 16'hffff;
  // Burst and auto-stop figures.
  localparam logic [4:0] FIFO_BEATS = 5'h10;
  localparam logic [2:0] LAST_BURST_CLK = 3'h7;
  localparam int AUTO_STOP_UNIT_LOG2 = 4;
  // Controller-side timing, in ns, in sys_clk cycles and in ck cycles.
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_MIN_RUN_NS = 200;
  localparam int OSC_MIN_RUN_CYC = (OSC_MIN_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_READOUT_NS = 40;
  localparam int OSC_READOUT_CYC = (OSC_READOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_READOUT_NCK = 8;
  // Command that must be closed by a CAS-2.
  typedef enum logic [2:0] {
    WAIT_NONE = 3'b000,
    WAIT_RD_CAL = 3'b001,
    WAIT_RD_FIFO = 3'b010,
    WAIT_WR_FIFO = 3'b011,
    WAIT_MRR = 3'b100
  } dtcu_wait_e;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_EDGE2 = 2'b01
  } dtcu_dec_e;
endpackage

// ==== dv/dtcu_ctrl_model.sv ====
// Controller-side model of the command bus: two-edge commands on ck.
// Assumes the unit samples cs and ca on the rising edge of ck.
`timescale 1ns/1ps
`default_nettype none
module dtcu_ctrl_model (
  // Link clock
  input wire logic ck,
  // Command bus
  output logic cs,
  output logic [5:0] ca
);
  initial begin
    cs = 1'b0;
    ca = 6'h00;
  end
  task automatic cmd(input logic [4:0] code, input logic a5, input logic [5:0] b);
    @(posedge ck);
    #1;
    cs = 1'b1;
    ca = {a5, code};
    @(posedge ck);
    #1;
    cs = 1'b0;
    ca = b;
  endtask
  // Deselected cycles toggle ca so that no stale operand looks valid.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ck);
      #1;
      ca = ~ca;
    end
  endtask
  task automatic mpc(input logic [6:0] op);
    cmd(dtcu_pkg::CMD_MPC, op[6], op[5:0]);
  endtask
  task automatic cas2();
    cmd(dtcu_pkg::CMD_CAS2, 1'b0, 6'h00);
  endtask
  task automatic rdcal();
    mpc(dtcu_pkg::OP_RD_CAL);
    cas2();
  endtask
  task automatic mrw(input logic [5:0] ad, input logic [7:0] d);
    cmd(dtcu_pkg::CMD_MRW1, d[7], ad);
    cmd(dtcu_pkg::CMD_MRW2, d[6], d[5:0]);
  endtask
  task automatic mrr(input logic [5:0] ad);
    cmd(dtcu_pkg::CMD_MRR1, 1'b0, ad);
    cas2();
  endtask
endmodule // dtcu_ctrl_model
`default_nettype wire

// ==== dv/dtcu_unit_chk.sv ====
// Concurrent checks on the training command unit, all on the ck domain.
// Assumes cs and ca are sampled on rising ck, as the unit does.
`timescale 1ns/1ps
`default_nettype none
module dtcu_unit_chk #(
  parameter int RD_LAT = 14
) (
  // Link clock and reset
  input wire logic ck,
  input wire logic rstn,
  // Command bus
  input wire logic cs,
  input wire logic [5:0] ca,
  // Read burst
  input wire logic dq_oe,
  input wire logic [1:0] dmi_rise,
  input wire logic [1:0] dmi_fall,
  input wire logic dqs_t_rise,
  input wire logic dqs_t_fall,
  input wire logic dqs_c_rise,
  input wire logic dqs_c_fall,
  input wire logic dqs_oe,
  // Training side effects
  input wire logic fifo_wr_go,
  input wire logic fifo_rd_go,
  input wire logic [4:0] train_beats,
  input wire logic zq_start,
  input wire logic zq_latch
);
  logic p_cs;
  logic [5:0] p_ca;
  logic mpc_b;
  logic cas_b;
  logic zs_hit;
  logic zl_hit;
  logic [6:0] op;
  default clocking cb @(posedge ck); endclocking
  default disable iff (!rstn);
  always_ff @(posedge ck or negedge rstn) begin
    if (!rstn) begin
      p_cs <= 1'b0;
      p_ca <= 6'h00;
    end else begin
      p_cs <= cs;
      p_ca <= ca;
    end
  end
  assign mpc_b = p_cs && !cs && p_ca[4:0] == dtcu_pkg::CMD_MPC;
  assign cas_b = p_cs && !cs && p_ca[4:0] == dtcu_pkg::CMD_CAS2;
  assign op = {p_ca[5], ca};
  assign zs_hit = mpc_b && op == dtcu_pkg::OP_ZQ_START;
  assign zl_hit = mpc_b && op == dtcu_pkg::OP_ZQ_LATCH;
  a_zq_start_decode: assert property (zs_hit |-> ##[1:2] zq_start)
    else $error("zq start pulse missing");
  a_zq_latch_decode: assert property (zl_hit |-> ##[1:2] zq_latch)
    else $error("zq latch pulse missing");
  a_zq_no_stray: assert property (zq_start |-> $past(zs_hit) || $past(zs_hit, 2))
    else $error("zq start without its command");
  a_fifo_one_wide: assert property (fifo_wr_go || fifo_rd_go |=> !fifo_wr_go && !fifo_rd_go)
    else $error("fifo pulse too wide");
  a_fifo_fixed_len: assert property (fifo_wr_go || fifo_rd_go |-> train_beats == 5'h10)
    else $error("fifo burst length not sixteen");
  a_fifo_after_cas: assert property (fifo_wr_go |-> $past(cas_b) || $past(cas_b, 2))
    else $error("fifo go without cas2");
  a_burst_latency: assert property ($rose(dq_oe) |-> $past(cas_b, RD_LAT) || $past(cas_b, RD_LAT + 1))
    else $error("burst start not at read latency");
  a_burst_length: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("burst shorter than sixteen beats");
  a_strobe_toggle: assert property (dq_oe |-> dqs_oe && dqs_t_rise && !dqs_t_fall && !dqs_c_rise && dqs_c_fall)
    else $error("strobe not toggling in burst");
  a_preamble_level: assert property (dqs_oe && !dq_oe |-> !dqs_t_rise && !dqs_t_fall && dqs_c_rise && dqs_c_fall)
    else $error("strobe not parked in training");
  a_dmi_same_bit: assert property (dq_oe |-> dmi_rise[0] == dmi_rise[1] && dmi_fall[0] == dmi_fall[1])
    else $error("mask pins disagree");
endmodule // dtcu_unit_chk
bind dtcu_unit dtcu_unit_chk #(.RD_LAT(RD_LAT)) i_chk (.ck(ck), .rstn(rstn), .cs(cs), .ca(ca),
  .dq_oe(dq_oe), .dmi_rise(dmi_rise), .dmi_fall(dmi_fall), .dqs_t_rise(dqs_t_rise),
  .dqs_t_fall(dqs_t_fall), .dqs_c_rise(dqs_c_rise), .dqs_c_fall(dqs_c_fall), .dqs_oe(dqs_oe),
  .fifo_wr_go(fifo_wr_go), .fifo_rd_go(fifo_rd_go), .train_beats(train_beats),
  .zq_start(zq_start), .zq_latch(zq_latch));
`default_nettype wire

// ==== dv/dtcu_unit_test.sv ====
// Self-checking bench for the training command unit.
// Assumes the controller model drives cs and ca; RD_LAT is left at 14.
`timescale 1ns/1ps
`default_nettype none
module dtcu_unit_test;
  logic sys_clk, ck, rstn, ce, cs, dq_oe, dqs_oe, fifo_wr_go, fifo_rd_go, zq_start, zq_latch;
  logic [5:0] ca;
  logic [15:0] dq_rise, dq_fall;
  logic [1:0] dmi_rise, dmi_fall;
  logic dqs_t_rise, dqs_t_fall, dqs_c_rise, dqs_c_fall;
  logic [4:0] train_beats;
  logic [15:0] bq [32];
  logic [1:0] bm [32];
  logic bo [16];
  logic [7:0] n_zs = 8'h00, n_zl = 8'h00, n_fw = 8'h00, n_fr = 8'h00;
  logic [31:0] bs;
  int miscompares, check_count;
  logic [5:0] ads [4] = '{6'h20, 6'h28, 6'h0f, 6'h14};
  logic [7:0] vals [4] = '{8'h5c, 8'ha3, 8'hf0, 8'h0f};
  logic [6:0] ops [8] = '{7'h4f, 7'h51, 7'h41, 7'h47, 7'h0f, 7'h45, 7'h49, 7'h7f};
  dtcu_unit #(.RD_LAT(14)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .ck(ck),
    .cs(cs), .ca(ca), .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe(dq_oe),
    .dmi_rise(dmi_rise), .dmi_fall(dmi_fall), .dqs_t_rise(dqs_t_rise),
    .dqs_t_fall(dqs_t_fall), .dqs_c_rise(dqs_c_rise), .dqs_c_fall(dqs_c_fall),
    .dqs_oe(dqs_oe), .fifo_wr_go(fifo_wr_go), .fifo_rd_go(fifo_rd_go),
    .train_beats(train_beats), .zq_start(zq_start), .zq_latch(zq_latch));
  dtcu_ctrl_model i_ctl (.ck(ck), .cs(cs), .ca(ca));
  always #12.5 sys_clk = ~sys_clk;
  initial begin
    #3.7;
    forever #6 ck = ~ck;
  end
  always @(posedge ck) begin
    n_zs <= n_zs + 8'(zq_start);
    n_zl <= n_zl + 8'(zq_latch);
    n_fw <= n_fw + 8'(fifo_wr_go);
    n_fr <= n_fr + 8'(fifo_rd_go);
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Collects n ck of beats from the first driven cycle onward.
  task automatic grab(input int n);
    int w;
    w = 0;
    @(negedge ck);
    while (dq_oe !== 1'b1 && w < 80) begin
      @(negedge ck);
      w++;
    end
    for (int j = 0; j < n; j++) begin
      bq[2 * j] = dq_rise;
      bq[2 * j + 1] = dq_fall;
      bm[2 * j] = dmi_rise;
      bm[2 * j + 1] = dmi_fall;
      bo[j] = dq_oe;
      @(negedge ck);
    end
  endtask
  task automatic rd(input logic [5:0] ad, output logic [7:0] v);
    i_ctl.mrr(ad);
    grab(8);
    v = bq[0][7:0];
    check("mrr_high_byte", bq[0][15:8], 8'h00);
  endtask
  task automatic osc(input int n, input logic stp, input logic [15:0] lo, input logic [15:0] hi,
      output logic [15:0] r);
    logic [7:0] a, b;
    i_ctl.mpc(dtcu_pkg::OP_OSC_START);
    i_ctl.idle(n);
    if (stp) i_ctl.mpc(dtcu_pkg::OP_OSC_STOP);
    i_ctl.idle(16);
    rd(dtcu_pkg::MA_OSC_LOW, a);
    rd(dtcu_pkg::MA_OSC_HIGH, b);
    // A full-scale result would be discarded by a real controller.
    check("osc_count", {b, a} >= lo && {b, a} <= hi, 1'b1);
    r = {b, a};
  endtask
  initial begin
    logic [7:0] v;
    logic [15:0] pat;
    logic bt;
    logic [15:0] cnt;
    sys_clk = 1'b0;
    ck = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    check("reset_outputs", {dq_oe, dqs_oe, zq_start, fifo_rd_go}, 4'h0);
    rd(dtcu_pkg::MA_PAT_FIRST, v);
    check("pattern_reset", v, dtcu_pkg::RST_PAT_FIRST);
    for (int i = 0; i < 4; i++) i_ctl.mrw(ads[i], vals[i]);
    for (int i = 0; i < 4; i++) begin
      rd(ads[i], v);
      check("reg_readback", v, vals[i]);
    end
    i_ctl.rdcal();
    // Four idle ck after a pair gives the 8 ck spacing that makes bursts seamless.
    i_ctl.idle(4);
    i_ctl.rdcal();
    grab(16);
    pat = {vals[1], vals[0]};
    for (int k = 0; k < 32; k++) begin
      bt = pat[k % 16];
      check("cal_dq", bq[k], {16{bt}} ^ {vals[3], vals[2]});
      check("cal_dmi", bm[k], {2{bt}});
    end
    for (int j = 0; j < 16; j++) check("seamless_oe", bo[j], 1'b1);
    for (int i = 0; i < 8; i++) begin
      bs = {n_zs, n_zl, n_fw, n_fr};
      i_ctl.mpc(ops[i]);
      i_ctl.cas2();
      i_ctl.idle(4);
      check("zq_start", n_zs - bs[31:24], ops[i] == dtcu_pkg::OP_ZQ_START);
      check("zq_latch", n_zl - bs[23:16], ops[i] == dtcu_pkg::OP_ZQ_LATCH);
      check("fifo_rd", n_fr - bs[7:0], ops[i] == dtcu_pkg::OP_RD_FIFO);
      check("fifo_wr", n_fw - bs[15:8], ops[i] == dtcu_pkg::OP_WR_FIFO);
    end
    // A reset in mid-run must bring the registers back to their reset values.
    rstn = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check("reset_midrun", {dq_oe, dqs_oe, zq_start, fifo_wr_go}, 4'h0);
    rstn = 1'b1;
    rd(dtcu_pkg::MA_PAT_FIRST, v);
    check("pattern_midrun", v, dtcu_pkg::RST_PAT_FIRST);
    i_ctl.mrw(dtcu_pkg::MA_TRAIN_CTRL, 8'h02);
    i_ctl.idle(3);
    @(negedge ck);
    check("train_park", {dqs_oe, dqs_t_rise, dqs_c_rise}, 3'b101);
    i_ctl.rdcal();
    i_ctl.idle(24);
    i_ctl.mrw(dtcu_pkg::MA_TRAIN_CTRL, 8'h00);
    i_ctl.idle(3);
    @(negedge ck);
    check("train_exit", dqs_oe, 1'b0);
    osc(140000, 1'b1, 16'hffff, 16'hffff, cnt);
    i_ctl.mrw(dtcu_pkg::MA_OSC_LOW, 8'h5a);
    rd(dtcu_pkg::MA_OSC_LOW, v);
    check("count_read_only", v, 8'hff);
    osc(20, 1'b1, 16'h0008, 16'h000d, cnt);
    i_ctl.mrw(dtcu_pkg::MA_AUTO_STOP, 8'h01);
    osc(60, 1'b0, 16'h0004, 16'h000b, cnt);
    i_ctl.mrw(dtcu_pkg::MA_AUTO_STOP, 8'h00);
    @(posedge sys_clk);
    #1;
    ce = 1'b0;
    // With the counter side frozen the result registers keep the last result.
    osc(20, 1'b1, cnt, cnt, cnt);
    summarize();
  end
  initial begin
    #2500000;
    miscompares++;
    summarize();
  end
endmodule // dtcu_unit_test
`default_nettype wire
